// *** hrw_params.svh ***
// Register offsets, field positions, reset values and timing counts for the hibernation block.
`ifndef HRW_PARAMS_SVH
`define HRW_PARAMS_SVH
`define HRW_OFS_RTC_COUNT     6'h00
`define HRW_OFS_MATCH0        6'h01
`define HRW_OFS_MATCH1        6'h02
`define HRW_OFS_LOAD          6'h03
`define HRW_OFS_CONTROL       6'h04
`define HRW_OFS_INT_MASK      6'h05
`define HRW_OFS_INT_RAW       6'h06
`define HRW_OFS_INT_MASKED    6'h07
`define HRW_OFS_INT_CLEAR     6'h08
`define HRW_OFS_TRIM          6'h09
`define HRW_OFS_SUBSEC        6'h0a
`define HRW_OFS_SUBSEC_MATCH  6'h0b
`define HRW_OFS_BATCHK        6'h0c
`define HRW_MEM_BASE          8'h40
`define HRW_MEM_WORDS         16
`define HRW_CTL_ENABLE        0
`define HRW_CTL_RTC_EN        1
`define HRW_CTL_CLK_SEL       2
`define HRW_CTL_WAKE_PIN      3
`define HRW_CTL_WAKE_RTC      4
`define HRW_CTL_WAKE_LOWBAT   5
`define HRW_CTL_LOWBAT_ABORT  6
`define HRW_CTL_HIB_REQ       7
`define HRW_CTL_ACTIVE        8
`define HRW_INT_MATCH0        0
`define HRW_INT_MATCH1        1
`define HRW_INT_LOWBAT        2
`define HRW_INT_PIN           3
`define HRW_TRIM_RESET        16'h7fff
`define HRW_SUBSEC_MAX        15'h7fff
`define HRW_XTAL_DIV          128
`define HRW_BATCHK_CYCLES     16'h0040
`endif

// *** hrw_pkg.sv ***
// Types shared by the hibernation block.
package hrw_pkg;
  typedef struct packed {
    logic       enable;
    logic       rtc_en;
    logic       clk_sel;
    logic       wake_pin;
    logic       wake_rtc;
    logic       wake_lowbat;
    logic       lowbat_abort;
  } hrw_ctl_t;
  typedef enum logic [3:0] {
    HRW_RUN   = 4'b0001,
    HRW_DEFER = 4'b0010,
    HRW_OFF   = 4'b0100,
    HRW_WAKE  = 4'b1000
  } hrw_state_t;
endpackage : hrw_pkg

// *** hrw_top.sv ***
// Hibernation controller with seconds counter, match, wake logic and backed memory.
//
// Summary of operation
// - 32-bit seconds and 15-bit subseconds counters readable.
// - Trim register adjusts counter rate.
// - Two match registers raise RTC events.
// - Sixteen backed words readable and writable.
// - RTC enable starts and stops counting.
// - Seconds count readable and loadable.
// - Subseconds match writable and readable.
// - Wake on pin, match, or both.
// - Low battery may act as wake.
// - Low battery flagged; optionally aborts hibernation.
// - Software starts battery check and polls completion.
// - Per-source enables, raw and masked status.
// - Hibernation request removes processor power.
// - Active status reported after power-on.
// - Status shows wake cause; memory kept.
// - Clock is raw slow tick or crystal/128.
// - Request deferred while battery check runs.
// - Check busy reads nonzero until finished.
//
// Added by the designer: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
`include "hrw_params.svh"
module hrw_top
  import hrw_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst,
  // Avalon-MM slave.
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Clock sources and pins.
  input  wire logic        slow_clk_tick,
  input  wire logic        xtal_clk_tick,
  input  wire logic        wake_pin,
  input  wire logic        battery_low,
  // Power control.
  output logic             processor_power_off
);
  hrw_ctl_t    ctl;
  hrw_state_t  state;
  logic [31:0] rtc_count;
  logic [14:0] subsec;
  logic [31:0] match0;
  logic [31:0] match1;
  logic [14:0] subsec_match;
  logic [15:0] trim;
  logic [3:0]  int_mask;
  logic [3:0]  int_raw;
  logic [6:0]  xtal_div;
  logic [15:0] batchk_cnt;
  logic        hib_req;
  logic        active;
  logic        acked;
  logic [31:0] mem [0:`HRW_MEM_WORDS-1];

  logic        access;
  logic        wr_en;
  logic        tick;
  logic        sec_step;
  logic        match0_hit;
  logic        match1_hit;
  logic        batchk_busy;
  logic        batchk_end;
  logic [3:0]  next_raw;
  logic [3:0]  clr_bits;
  logic        wake_event;
  logic        mem_sel;
  logic        reg_sel;

  // Writes land on the edge at which the master sees waitrequest low.
  assign access      = (avs_read | avs_write) & ~acked;
  assign wr_en       = avs_write & ~avs_waitrequest;
  assign mem_sel     = (avs_address[7:6] == 2'((`HRW_MEM_BASE) >> 6)) &&
                       (avs_address[5:4] == 2'b00);
  assign reg_sel     = (avs_address[7:6] == 2'b00);
  assign batchk_busy = (batchk_cnt != 16'h0000);
  assign batchk_end  = (batchk_cnt == 16'h0001);

  // One wait cycle per access; the answer comes on the second edge.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acked           <= 1'b0;
      avs_waitrequest <= 1'b1;
    end else begin
      acked           <= access;
      avs_waitrequest <= ~access;
    end
  end

  // Slow tick is the raw oscillator or the crystal tick divided by 128.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      xtal_div <= 7'h00;
    end else if (xtal_clk_tick) begin
      xtal_div <= xtal_div + 7'h01;
    end
  end
  assign tick = ctl.enable & ctl.rtc_en &
                (ctl.clk_sel ? (xtal_clk_tick && xtal_div == 7'h7f) : slow_clk_tick);

  // Subseconds counts up to the trim value, then wraps into the seconds count.
  assign sec_step = tick && ({1'b0, subsec} >= trim);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      subsec <= 15'h0000;
    end else if (wr_en && reg_sel && avs_address[5:0] == `HRW_OFS_LOAD) begin
      subsec <= 15'h0000;
    end else if (sec_step) begin
      subsec <= 15'h0000;
    end else if (tick) begin
      subsec <= subsec + 15'h0001;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rtc_count <= 32'h0000_0000;
    end else if (wr_en && reg_sel && avs_address[5:0] == `HRW_OFS_LOAD) begin
      rtc_count <= avs_writedata;
    end else if (sec_step) begin
      rtc_count <= rtc_count + 32'h0000_0001;
    end
  end

  // Configuration registers written by software.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctl          <= '0;
      match0       <= 32'hffff_ffff;
      match1       <= 32'hffff_ffff;
      subsec_match <= 15'h0000;
      trim         <= `HRW_TRIM_RESET;
      int_mask     <= 4'h0;
    end else if (wr_en && reg_sel) begin
      case (avs_address[5:0])
        `HRW_OFS_MATCH0: begin
          match0 <= avs_writedata;
        end
        `HRW_OFS_MATCH1: begin
          match1 <= avs_writedata;
        end
        `HRW_OFS_CONTROL: begin
          ctl.enable       <= avs_writedata[`HRW_CTL_ENABLE];
          ctl.rtc_en       <= avs_writedata[`HRW_CTL_RTC_EN];
          ctl.clk_sel      <= avs_writedata[`HRW_CTL_CLK_SEL];
          ctl.wake_pin     <= avs_writedata[`HRW_CTL_WAKE_PIN];
          ctl.wake_rtc     <= avs_writedata[`HRW_CTL_WAKE_RTC];
          ctl.wake_lowbat  <= avs_writedata[`HRW_CTL_WAKE_LOWBAT];
          ctl.lowbat_abort <= avs_writedata[`HRW_CTL_LOWBAT_ABORT];
        end
        `HRW_OFS_INT_MASK: begin
          int_mask <= avs_writedata[3:0];
        end
        `HRW_OFS_TRIM: begin
          trim <= avs_writedata[15:0];
        end
        `HRW_OFS_SUBSEC_MATCH: begin
          subsec_match <= avs_writedata[14:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Battery-backed words; reset does not touch them.
  always_ff @(posedge clk) begin
    if (wr_en && mem_sel) begin
      mem[avs_address[3:0]] <= avs_writedata;
    end
  end

  // Forced battery check runs for a fixed count of cycles.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      batchk_cnt <= 16'h0000;
    end else if (wr_en && reg_sel && avs_address[5:0] == `HRW_OFS_BATCHK &&
                 avs_writedata[0] && ctl.enable) begin
      batchk_cnt <= `HRW_BATCHK_CYCLES;
    end else if (batchk_busy) begin
      batchk_cnt <= batchk_cnt - 16'h0001;
    end
  end

  // Match 0 fires on the subsecond match tick of its second; match 1 fires as the count steps into its second.
  assign match0_hit = ctl.enable && tick && rtc_count == match0 && subsec == subsec_match;
  assign match1_hit = ctl.enable && sec_step && rtc_count + 32'h0000_0001 == match1;

  assign clr_bits = (wr_en && reg_sel && avs_address[5:0] == `HRW_OFS_INT_CLEAR) ?
                    avs_writedata[3:0] : 4'h0;
  always_comb begin
    next_raw                  = int_raw & ~clr_bits;
    next_raw[`HRW_INT_MATCH0] = next_raw[`HRW_INT_MATCH0] | match0_hit;
    next_raw[`HRW_INT_MATCH1] = next_raw[`HRW_INT_MATCH1] | match1_hit;
    next_raw[`HRW_INT_LOWBAT] = next_raw[`HRW_INT_LOWBAT] |
                                (ctl.enable & battery_low & (~batchk_busy | batchk_end));
    next_raw[`HRW_INT_PIN]    = next_raw[`HRW_INT_PIN] | (ctl.enable & wake_pin & ctl.wake_pin);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      int_raw <= 4'h0;
    end else begin
      int_raw <= next_raw;
    end
  end

  assign wake_event = (ctl.wake_pin & wake_pin) |
                      (ctl.wake_rtc & (match0_hit | match1_hit)) |
                      (ctl.wake_lowbat & battery_low);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hib_req <= 1'b0;
    end else if (state != HRW_RUN) begin
      hib_req <= 1'b0;
    end else if (wr_en && reg_sel && avs_address[5:0] == `HRW_OFS_CONTROL &&
                 avs_writedata[`HRW_CTL_HIB_REQ] && ctl.enable) begin
      hib_req <= 1'b1;
    end
  end

  // Power sequencing: run, defer behind a check, off, wake.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state               <= HRW_RUN;
      processor_power_off <= 1'b0;
    end else begin
      case (state)
        HRW_RUN: begin
          if (hib_req) begin
            state <= HRW_DEFER;
          end
        end
        HRW_DEFER: begin
          if (!batchk_busy) begin
            if (ctl.lowbat_abort && battery_low) begin
              state <= HRW_RUN;
            end else begin
              state               <= HRW_OFF;
              processor_power_off <= 1'b1;
            end
          end
        end
        HRW_OFF: begin
          if (wake_event) begin
            state               <= HRW_WAKE;
            processor_power_off <= 1'b0;
          end
        end
        HRW_WAKE: begin
          state <= HRW_RUN;
        end
        default: begin
          state <= HRW_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      active <= 1'b0;
    end else begin
      active <= ctl.enable;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !acked) begin
      if (mem_sel) begin
        avs_readdata <= mem[avs_address[3:0]];
      end else if (!reg_sel) begin
        avs_readdata <= 32'h0000_0000;
      end else begin
        case (avs_address[5:0])
          `HRW_OFS_RTC_COUNT:    avs_readdata <= rtc_count;
          `HRW_OFS_MATCH0:       avs_readdata <= match0;
          `HRW_OFS_MATCH1:       avs_readdata <= match1;
          `HRW_OFS_CONTROL:      avs_readdata <= {23'h00_0000, active, hib_req,
                                                  ctl.lowbat_abort, ctl.wake_lowbat,
                                                  ctl.wake_rtc, ctl.wake_pin, ctl.clk_sel,
                                                  ctl.rtc_en, ctl.enable};
          `HRW_OFS_INT_MASK:     avs_readdata <= {28'h000_0000, int_mask};
          `HRW_OFS_INT_RAW:      avs_readdata <= {28'h000_0000, int_raw};
          `HRW_OFS_INT_MASKED:   avs_readdata <= {28'h000_0000, int_raw & int_mask};
          `HRW_OFS_TRIM:         avs_readdata <= {16'h0000, trim};
          `HRW_OFS_SUBSEC:       avs_readdata <= {17'h0_0000, subsec};
          `HRW_OFS_SUBSEC_MATCH: avs_readdata <= {17'h0_0000, subsec_match};
          `HRW_OFS_BATCHK:       avs_readdata <= {31'h0000_0000, batchk_busy};
          default:               avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule : hrw_top

// *** hrw_chk_assertions.sv ***
// Bus handshake and power-off checks for the hibernation block.
`timescale 1ns/1ps
module hrw_chk (
  // Clock and reset.
  input wire logic        clk,
  input wire logic        rst,
  // Register bus.
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // Power control.
  input wire logic        processor_power_off
);
  logic [7:0] hib_age;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Cycles since an enabled hibernation request was taken; saturates when none is pending.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) hib_age <= 8'hff;
    else if (avs_write && avs_waitrequest && avs_address == 8'h04 && avs_writedata[7]
             && avs_writedata[0]) hib_age <= 8'h00;
    else if (hib_age != 8'hff) hib_age <= hib_age + 8'h01;
  end
  property p_ack; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
  property p_one; !avs_waitrequest |=> avs_waitrequest; endproperty
  property p_idle; !avs_read && !avs_write |=> avs_waitrequest; endproperty
  property p_hold; !avs_read |=> $stable(avs_readdata); endproperty
  property p_chg; $changed(avs_readdata) |-> avs_read && !avs_waitrequest; endproperty
  property p_unlo;
    avs_read && avs_waitrequest && avs_address inside {[8'h0d:8'h3f]} |=> avs_readdata == 32'h0;
  endproperty
  property p_unhi;
    avs_read && avs_waitrequest && avs_address inside {[8'h50:8'hff]} |=> avs_readdata == 32'h0;
  endproperty
  property p_hib; $rose(processor_power_off) |-> hib_age < 8'h64; endproperty
  a_ack: assert property (p_ack) else $error("no answer one cycle after request");
  a_one: assert property (p_one) else $error("answer held longer than one cycle");
  a_idle: assert property (p_idle) else $error("answer without request");
  a_hold: assert property (p_hold) else $error("read data moved without read");
  a_chg: assert property (p_chg) else $error("read data changed off an answer");
  a_unlo: assert property (p_unlo) else $error("unmapped low read not zero");
  a_unhi: assert property (p_unhi) else $error("unmapped high read not zero");
  a_hib: assert property (p_hib) else $error("power removed without request");
  c_wr: cover property (avs_write && !avs_waitrequest);
  c_rd: cover property (avs_read && !avs_waitrequest);
  c_off: cover property ($rose(processor_power_off));
endmodule : hrw_chk
bind hrw_top hrw_chk hrw_chk_i (.clk(clk), .rst(rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .processor_power_off(processor_power_off));

// *** hrw_top_tb_top.sv ***
// Self-checking bench for the hibernation block.
`timescale 1ns/1ps
module hrw_top_tb_top;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        slow_clk_tick = 1'b0;
  logic        xtal_clk_tick = 1'b0;
  logic        wake_pin = 1'b0;
  logic        battery_low = 1'b0;
  logic        processor_power_off;
  int          failures = 0;
  int          comparisons = 0;
  int          seed = 28;
  int          mem_q [$];
  int          secs;
  int          trim_m;
  logic [31:0] d;
  logic [7:0]  regs [5] = '{8'h01, 8'h02, 8'h09, 8'h0b, 8'h05};
  logic [31:0] msk [5] = '{32'hffff_ffff, 32'hffff_ffff, 32'hffff, 32'h7fff, 32'hf};
  always #25 clk = ~clk;
  hrw_top hrw_top_i (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .slow_clk_tick(slow_clk_tick),
    .xtal_clk_tick(xtal_clk_tick), .wake_pin(wake_pin), .battery_low(battery_low),
    .processor_power_off(processor_power_off));
  task automatic stop_test;
    if (failures == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : cmp
  task automatic ack;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
  endtask : ack
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= v;
    avs_write <= 1'b1;
    ack();
    avs_write <= 1'b0;
  endtask : wr
  // Reads a word and compares the masked bits with the model value.
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clk);
    avs_address <= a;
    avs_read <= 1'b1;
    ack();
    d = avs_readdata;
    avs_read <= 1'b0;
    cmp($sformatf("reg %h", a), e, d & m);
  endtask : rd
  task automatic tick(input int n, input logic x);
    repeat (n) begin
      @(posedge clk);
      slow_clk_tick <= !x;
      xtal_clk_tick <= x;
      @(posedge clk);
      slow_clk_tick <= 1'b0;
      xtal_clk_tick <= 1'b0;
    end
  endtask : tick
  task automatic wait_off(input logic v);
    for (int i = 0; i < 300 && processor_power_off !== v; i++) @(posedge clk);
    cmp("power_off", {31'h0, v}, {31'h0, processor_power_off});
  endtask : wait_off
  initial begin
    #1000000;
    failures++;
    stop_test();
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(8'h09, 32'hffff, 32'h7fff);
    rd(8'h04, 32'h1ff, 32'h0);
    wr(8'h04, 32'h80);
    repeat (10) @(posedge clk);
    cmp("power_off", 32'h0, {31'h0, processor_power_off});
    wr(8'h04, 32'h3);
    foreach (regs[i]) begin
      d = $random(seed);
      wr(regs[i], d);
      rd(regs[i], msk[i], d & msk[i]);
    end
    for (int i = 0; i < 16; i++) begin
      mem_q.push_back($random(seed));
      wr(8'h40 + i[7:0], mem_q[i]);
    end
    for (int i = 0; i < 16; i++) rd(8'h40 + i[7:0], '1, mem_q[i]);
    wr(8'h20, 32'h5a5a_5a5a);
    rd(8'h20, '1, 32'h0);
    rd(8'h50, '1, 32'h0);
    trim_m = 3;
    secs = 5;
    wr(8'h09, trim_m);
    wr(8'h03, secs);
    tick(8, 1'b0);
    secs += 8 / (trim_m + 1);
    rd(8'h00, '1, secs);
    rd(8'h0a, '1, 32'h0);
    wr(8'h04, 32'h1);
    tick(4, 1'b0);
    rd(8'h00, '1, secs);
    wr(8'h04, 32'h7);
    repeat (4) @(posedge clk);
    tick(512, 1'b1);
    secs += 512 / 128 / (trim_m + 1);
    rd(8'h00, '1, secs);
    wr(8'h02, secs + 1);
    wr(8'h05, 32'h2);
    wr(8'h08, 32'hf);
    wr(8'h04, 32'h3);
    tick(4, 1'b0);
    secs += 4 / (trim_m + 1);
    rd(8'h06, 32'h2, 32'h2);
    rd(8'h07, 32'h2, 32'h2);
    wr(8'h08, 32'h2);
    rd(8'h06, 32'h2, 32'h0);
    wr(8'h01, secs);
    wr(8'h0b, 32'h2);
    tick(3, 1'b0);
    rd(8'h06, 32'h1, 32'h1);
    rd(8'h07, 32'h1, 32'h0);
    wr(8'h0c, 32'h1);
    battery_low <= 1'b1;
    rd(8'h0c, 32'h1, 32'h1);
    rd(8'h06, 32'h4, 32'h0);
    repeat (70) @(posedge clk);
    rd(8'h0c, 32'h1, 32'h0);
    rd(8'h06, 32'h4, 32'h4);
    battery_low <= 1'b0;
    wr(8'h08, 32'h4);
    wr(8'h0c, 32'h1);
    wr(8'h04, 32'h8b);
    repeat (30) @(posedge clk);
    cmp("power_off", 32'h0, {31'h0, processor_power_off});
    wait_off(1'b1);
    wake_pin <= 1'b1;
    wait_off(1'b0);
    wake_pin <= 1'b0;
    rd(8'h06, 32'h8, 32'h8);
    rd(8'h04, 32'h100, 32'h100);
    rd(8'h40, '1, mem_q[0]);
    wr(8'h08, 32'hf);
    battery_low <= 1'b1;
    wr(8'h04, 32'hcb);
    repeat (20) @(posedge clk);
    cmp("power_off", 32'h0, {31'h0, processor_power_off});
    rd(8'h04, 32'h80, 32'h0);
    stop_test();
  end
endmodule : hrw_top_tb_top
